// ==== sfpl_top.sv ====
// Serial command front end and protection lock logic of the flash
`default_nettype none
`include "sfpl_cfg.svh"
module sfpl_top #(
  parameter int UNLOCK_CYC = `SFPL_UNLOCK_NS / `SFPL_CLK_NS
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  input wire logic sw_reset_in,
  input wire logic busy_in,
  input wire logic read_prot_in,
  input wire logic [1:0] protection_config_reg_nv_in,
  input wire logic [7:0] arr_rdata_in,
  output logic [31:0] arr_addr_out,
  output logic arr_rd_out,
  output logic arr_ecc_out,
  output logic ppb_prog_out,
  output logic ppb_erase_out,
  output logic asp_prog_out,
  output logic [1:0] asp_wdata_out,
  output logic lock_out,
  output logic wip_out,
  output logic perr_out
);
  // ----------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------
  logic rst_s1_r, rst_n;
  logic [5:0] pin_s1_r, pin_s2_r;
  logic sck_d_r, cs_d_r;
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_s1_r <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n <= rst_s1_r;
    end
  end
  // Sck at 160 ns leaves four clocks per phase after the sync delay
  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Idle levels: select high, clock low, so no false edge follows reset
      pin_s1_r <= 6'h20;
      pin_s2_r <= 6'h20;
      sck_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end
    else
    begin
      pin_s1_r <= {cs_n_in, sck_in, io_in};
      pin_s2_r <= pin_s1_r;
      sck_d_r <= pin_s2_r[4];
      cs_d_r <= pin_s2_r[5];
    end
  end
  logic cs_n, sck_rise, sck_fall, cs_rise, cs_fall;
  logic [3:0] io;
  assign cs_n = pin_s2_r[5];
  assign io = pin_s2_r[3:0];
  assign sck_rise = pin_s2_r[4] & ~sck_d_r & ~cs_n;
  assign sck_fall = ~pin_s2_r[4] & sck_d_r & ~cs_n;
  assign cs_rise = cs_n & ~cs_d_r;
  assign cs_fall = ~cs_n & cs_d_r;

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  function automatic sfpl_pkg::sfpl_cmd_s decode(input logic [7:0] op);
    sfpl_pkg::sfpl_cmd_s c;
    c = '{sfpl_pkg::K_NONE, 3'h1, 3'h1, 1'b0, 1'b0, 1'b0, 4'h0};
    case (op)
      `SFPL_OP_READ, `SFPL_OP_READ4:
        c = '{sfpl_pkg::K_READ, 3'h1, 3'h1, 1'b1, 1'b0, 1'b0, 4'h0};
      `SFPL_OP_FAST, `SFPL_OP_FAST4:
        c = '{sfpl_pkg::K_READ, 3'h1, 3'h1, 1'b1, 1'b0, 1'b0,
          `SFPL_DUMMY_FAST};
      `SFPL_OP_DOR, `SFPL_OP_DOR4:
        c = '{sfpl_pkg::K_READ, 3'h1, 3'h2, 1'b1, 1'b0, 1'b0,
          `SFPL_DUMMY_FAST};
      `SFPL_OP_QOR, `SFPL_OP_QOR4:
        c = '{sfpl_pkg::K_READ, 3'h1, 3'h4, 1'b1, 1'b0, 1'b0,
          `SFPL_DUMMY_FAST};
      `SFPL_OP_DIOR, `SFPL_OP_DIOR4:
        c = '{sfpl_pkg::K_READ, 3'h2, 3'h2, 1'b1, 1'b0, 1'b1, 4'h0};
      `SFPL_OP_QIOR, `SFPL_OP_QIOR4:
        c = '{sfpl_pkg::K_READ, 3'h4, 3'h4, 1'b1, 1'b0, 1'b1,
          `SFPL_DUMMY_QIO};
      `SFPL_OP_RDSR1: c.kind = sfpl_pkg::K_STAT;
      `SFPL_OP_CLSR: c.kind = sfpl_pkg::K_CLSR;
      `SFPL_OP_ECCRD:
        c = '{sfpl_pkg::K_ECC, 3'h1, 3'h1, 1'b1, 1'b1, 1'b0,
          `SFPL_DUMMY_FAST};
      `SFPL_OP_LCLR: c.kind = sfpl_pkg::K_LCLR;
      `SFPL_OP_PWRD: c.kind = sfpl_pkg::K_PWRD;
      `SFPL_OP_PWPG: c.kind = sfpl_pkg::K_PWPG;
      `SFPL_OP_UNLK: c.kind = sfpl_pkg::K_UNLK;
      `SFPL_OP_PPBP:
        c = '{sfpl_pkg::K_PPBP, 3'h1, 3'h1, 1'b1, 1'b1, 1'b0, 4'h0};
      `SFPL_OP_PPBE: c.kind = sfpl_pkg::K_PPBE;
      `SFPL_OP_ASPP: c.kind = sfpl_pkg::K_ASPP;
      default: c.kind = sfpl_pkg::K_NONE;
    endcase
    // 4-byte opcodes except READ4 (13h) carry bit 2 set in their low nibble pattern
    if (op == `SFPL_OP_READ4 || op == `SFPL_OP_FAST4 ||
        op == `SFPL_OP_DOR4 || op == `SFPL_OP_QOR4 ||
        op == `SFPL_OP_DIOR4 || op == `SFPL_OP_QIOR4)
      c.addr4 = 1'b1;
    return c;
  endfunction

  // ----------------------------------------------------------------
  // Command engine
  // ----------------------------------------------------------------
  sfpl_pkg::sfpl_state_e st_r, st_nxt;
  sfpl_pkg::sfpl_cmd_s cmd_r, cmd_nxt, dc;
  logic [5:0] cnt_r, cnt_nxt;
  logic [2:0] tot_r, tot_nxt;
  logic [3:0] byte_r, byte_nxt;
  logic [7:0] sh_r, sh_nxt, ob_r, ob_nxt;
  logic [3:0] ocnt_r, ocnt_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic cont_r, cont_nxt, init_r, init_nxt;
  logic lock_r, lock_nxt, wip_r, wip_nxt, perr_r, perr_nxt;
  logic [63:0] pw_r, pw_nxt, pwbuf_r, pwbuf_nxt;
  logic [1:0] aspw_r, aspw_nxt;
  logic [15:0] tmr_r, tmr_nxt;
  logic [3:0] do_r, do_nxt, oe_r, oe_nxt;
  logic rd_nxt, pp_nxt, pe_nxt, ap_nxt;
  logic [7:0] inst, bin, src, stat;
  logic [5:0] alen;
  logic pw_sealed, arr_kind;

  assign pw_sealed = ~protection_config_reg_nv_in[1];
  assign arr_kind = cmd_r.kind == sfpl_pkg::K_READ;
  assign alen = cmd_r.addr4 ? 6'd32 : 6'd24;
  assign inst = {sh_r[6:0], io[0]};
  assign bin = {sh_r[6:0], io[0]};
  assign dc = decode(inst);

  always_comb
  begin
    stat = 8'h00;
    stat[`SFPL_SR1_WIP] = wip_r | busy_in;
    stat[`SFPL_SR1_PERR] = perr_r;
    case (cmd_r.kind)
      sfpl_pkg::K_STAT: src = stat;
      sfpl_pkg::K_PWRD: src = pw_r[{addr_r[2:0], 3'h0} +: 8];
      default: src = arr_rdata_in;
    endcase
  end

  always_comb
  begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    cnt_nxt = cnt_r;
    tot_nxt = tot_r;
    byte_nxt = byte_r;
    sh_nxt = sh_r;
    ob_nxt = ob_r;
    ocnt_nxt = ocnt_r;
    addr_nxt = addr_r;
    cont_nxt = cont_r;
    init_nxt = 1'b0;
    lock_nxt = lock_r;
    wip_nxt = wip_r;
    perr_nxt = perr_r;
    pw_nxt = pw_r;
    pwbuf_nxt = pwbuf_r;
    aspw_nxt = aspw_r;
    tmr_nxt = (tmr_r != 16'h0) ? tmr_r - 16'h1 : tmr_r;
    do_nxt = do_r;
    oe_nxt = oe_r;
    rd_nxt = 1'b0;
    pp_nxt = 1'b0;
    pe_nxt = 1'b0;
    ap_nxt = 1'b0;
    // Strap-like capture of the lock level one clock after release
    if (init_r)
      lock_nxt = (protection_config_reg_nv_in == `SFPL_PROTECTION_CONFIG_REG_PASSWORD) ? 1'b0 : 1'b1;
    if (sw_reset_in)
    begin
      st_nxt = sfpl_pkg::ST_IDLE;
      cont_nxt = 1'b0;
      oe_nxt = 4'h0;
    end
    else if (cs_rise)
    begin
      st_nxt = sfpl_pkg::ST_IDLE;
      oe_nxt = 4'h0;
      if (tot_r == 3'h0 && (st_r == sfpl_pkg::ST_SKIP ||
          st_r == sfpl_pkg::ST_DIN))
        case (cmd_r.kind)
          sfpl_pkg::K_LCLR: lock_nxt = 1'b0;
          sfpl_pkg::K_CLSR:
          begin
            perr_nxt = 1'b0;
            wip_nxt = 1'b0;
          end
          sfpl_pkg::K_UNLK:
            if (byte_r == `SFPL_PW_BYTES && tmr_r == 16'h0 &&
                protection_config_reg_nv_in == `SFPL_PROTECTION_CONFIG_REG_PASSWORD)
            begin
              if (pwbuf_r == pw_r)
                lock_nxt = 1'b1;
              else
              begin
                perr_nxt = 1'b1;
                wip_nxt = 1'b1;
                tmr_nxt = 16'(UNLOCK_CYC);
              end
            end
          sfpl_pkg::K_PPBP, sfpl_pkg::K_PPBE:
            if (!lock_r)
            begin
              perr_nxt = 1'b1;
              wip_nxt = 1'b1;
            end
            else
            begin
              pp_nxt = cmd_r.kind == sfpl_pkg::K_PPBP;
              pe_nxt = cmd_r.kind == sfpl_pkg::K_PPBE;
            end
          sfpl_pkg::K_ASPP:
            // No erase path: a programmed mode pair never changes
            if (byte_r != 4'h0 && protection_config_reg_nv_in == `SFPL_PROTECTION_CONFIG_REG_BLANK)
            begin
              if (aspw_r == `SFPL_PROTECTION_CONFIG_REG_ILLEGAL)
              begin
                perr_nxt = 1'b1;
                wip_nxt = 1'b1;
              end
              else
                ap_nxt = 1'b1;
            end
          default: ;
        endcase
    end
    else if (cs_fall && st_r == sfpl_pkg::ST_IDLE)
    begin
      cnt_nxt = 6'h0;
      tot_nxt = 3'h0;
      byte_nxt = 4'h0;
      ocnt_nxt = 4'h0;
      addr_nxt = 32'h0;
      st_nxt = cont_r ? sfpl_pkg::ST_ADDR : sfpl_pkg::ST_INST;
    end
    else if (sck_rise)
    begin
      tot_nxt = tot_r + 3'h1;
      sh_nxt = bin;
      cnt_nxt = cnt_r + 6'h1;
      case (st_r)
        sfpl_pkg::ST_INST:
          if (cnt_r == 6'd7)
          begin
            cmd_nxt = dc;
            cnt_nxt = 6'h0;
            st_nxt = sfpl_pkg::ST_SKIP;
            if (busy_in && dc.kind != sfpl_pkg::K_STAT &&
                dc.kind != sfpl_pkg::K_CLSR)
              cmd_nxt.kind = sfpl_pkg::K_NONE;
            else if (pw_sealed && (dc.kind == sfpl_pkg::K_PWRD ||
                     dc.kind == sfpl_pkg::K_PWPG))
              cmd_nxt.kind = sfpl_pkg::K_NONE;
            else if (dc.has_addr)
              st_nxt = sfpl_pkg::ST_ADDR;
            else if (dc.kind == sfpl_pkg::K_STAT ||
                     dc.kind == sfpl_pkg::K_PWRD)
              st_nxt = sfpl_pkg::ST_DOUT;
            else if (dc.kind == sfpl_pkg::K_PWPG ||
                     dc.kind == sfpl_pkg::K_UNLK ||
                     dc.kind == sfpl_pkg::K_ASPP)
              st_nxt = sfpl_pkg::ST_DIN;
          end
        sfpl_pkg::ST_ADDR:
        begin
          case (cmd_r.alanes)
            3'h4: addr_nxt = {addr_r[27:0], io};
            3'h2: addr_nxt = {addr_r[29:0], io[1:0]};
            default: addr_nxt = {addr_r[30:0], io[0]};
          endcase
          cnt_nxt = cnt_r + 6'(cmd_r.alanes);
          if (cnt_nxt == alen)
          begin
            cnt_nxt = 6'h0;
            if (cmd_r.has_mode)
              st_nxt = sfpl_pkg::ST_MODE;
            else if (cmd_r.kind == sfpl_pkg::K_PPBP)
              st_nxt = sfpl_pkg::ST_SKIP;
            else if (cmd_r.dummy != 4'h0)
              st_nxt = sfpl_pkg::ST_DUMMY;
            else
              st_nxt = sfpl_pkg::ST_DOUT;
          end
        end
        sfpl_pkg::ST_MODE:
        begin
          case (cmd_r.alanes)
            3'h4: sh_nxt = {sh_r[3:0], io};
            default: sh_nxt = {sh_r[5:0], io[1:0]};
          endcase
          cnt_nxt = cnt_r + 6'(cmd_r.alanes);
          if (cnt_nxt == 6'd8)
          begin
            cnt_nxt = 6'h0;
            cont_nxt = sh_nxt[7:4] == `SFPL_CONT_NIBBLE;
            st_nxt = (cmd_r.dummy != 4'h0) ? sfpl_pkg::ST_DUMMY :
              sfpl_pkg::ST_DOUT;
          end
        end
        sfpl_pkg::ST_DUMMY:
          if (cnt_r + 6'h1 == 6'(cmd_r.dummy))
            st_nxt = sfpl_pkg::ST_DOUT;
        sfpl_pkg::ST_DIN:
          if (cnt_r == 6'd7)
          begin
            cnt_nxt = 6'h0;
            if (byte_r != `SFPL_PW_BYTES)
              byte_nxt = byte_r + 4'h1;
            case (cmd_r.kind)
              sfpl_pkg::K_PWPG:
                if (byte_r != `SFPL_PW_BYTES)
                  pw_nxt[{byte_r[2:0], 3'h0} +: 8] =
                    pw_r[{byte_r[2:0], 3'h0} +: 8] & bin;
              sfpl_pkg::K_UNLK:
                if (byte_r != `SFPL_PW_BYTES)
                  pwbuf_nxt[{byte_r[2:0], 3'h0} +: 8] = bin;
              default: aspw_nxt = bin[2:1];
            endcase
          end
        default: ;
      endcase
      if (st_nxt == sfpl_pkg::ST_DOUT && st_r != sfpl_pkg::ST_DOUT)
        rd_nxt = 1'b1;
    end
    else if (sck_fall && st_r == sfpl_pkg::ST_DOUT)
    begin
      ob_nxt = ob_r;
      if (ocnt_r == 4'h0)
      begin
        ob_nxt = src;
        ocnt_nxt = 4'h8;
        addr_nxt = addr_r + 32'h1;
        rd_nxt = 1'b1;
      end
      case (cmd_r.dlanes)
        3'h4:
        begin
          do_nxt = ob_nxt[7:4];
          oe_nxt = 4'hf;
          ob_nxt = {ob_nxt[3:0], 4'h0};
        end
        3'h2:
        begin
          do_nxt = {2'h0, ob_nxt[7:6]};
          oe_nxt = 4'h3;
          ob_nxt = {ob_nxt[5:0], 2'h0};
        end
        default:
        begin
          do_nxt = {2'h0, ob_nxt[7], 1'b0};
          oe_nxt = 4'h2;
          ob_nxt = {ob_nxt[6:0], 1'b0};
        end
      endcase
      ocnt_nxt = ocnt_nxt - {1'b0, cmd_r.dlanes};
      if (arr_kind && busy_in)
        oe_nxt = 4'h0;
    end
  end

  always_ff @(posedge clock_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= sfpl_pkg::ST_IDLE;
      cmd_r <= '{sfpl_pkg::K_NONE, 3'h1, 3'h1, 1'b0, 1'b0, 1'b0, 4'h0};
      cnt_r <= 6'h0;
      tot_r <= 3'h0;
      byte_r <= 4'h0;
      sh_r <= 8'h00;
      ob_r <= 8'h00;
      ocnt_r <= 4'h0;
      addr_r <= 32'h0;
      cont_r <= 1'b0;
      init_r <= 1'b1;
      lock_r <= 1'b0;
      wip_r <= 1'b0;
      perr_r <= 1'b0;
      pw_r <= `SFPL_PW_RESET;
      pwbuf_r <= 64'h0;
      aspw_r <= `SFPL_PROTECTION_CONFIG_REG_BLANK;
      tmr_r <= 16'h0;
      do_r <= 4'h0;
      oe_r <= 4'h0;
      arr_rd_out <= 1'b0;
      ppb_prog_out <= 1'b0;
      ppb_erase_out <= 1'b0;
      asp_prog_out <= 1'b0;
      arr_addr_out <= 32'h0;
    end
    else
    begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      cnt_r <= cnt_nxt;
      tot_r <= tot_nxt;
      byte_r <= byte_nxt;
      sh_r <= sh_nxt;
      ob_r <= ob_nxt;
      ocnt_r <= ocnt_nxt;
      addr_r <= addr_nxt;
      cont_r <= cont_nxt;
      init_r <= init_nxt;
      lock_r <= lock_nxt;
      wip_r <= wip_nxt;
      perr_r <= perr_nxt;
      pw_r <= pw_nxt;
      pwbuf_r <= pwbuf_nxt;
      aspw_r <= aspw_nxt;
      tmr_r <= tmr_nxt;
      do_r <= do_nxt;
      oe_r <= oe_nxt;
      arr_rd_out <= rd_nxt & ~busy_in & (arr_kind |
        cmd_r.kind == sfpl_pkg::K_ECC | cmd_nxt.kind == sfpl_pkg::K_READ);
      ppb_prog_out <= pp_nxt;
      ppb_erase_out <= pe_nxt;
      asp_prog_out <= ap_nxt;
      // Read-protected ECC status always comes from the boot sector
      arr_addr_out <= (cmd_nxt.kind == sfpl_pkg::K_ECC && read_prot_in) ?
        `SFPL_BOOT_ADDR : addr_nxt;
    end
  end

  assign io_out = do_r;
  assign io_oe_out = oe_r;
  assign arr_ecc_out = cmd_r.kind == sfpl_pkg::K_ECC;
  assign asp_wdata_out = aspw_r;
  assign lock_out = lock_r;
  assign wip_out = wip_r | busy_in;
  assign perr_out = perr_r;
endmodule
`default_nettype wire

// ==== sfpl_cfg.svh ====
// Constants of the serial flash command front end with protection lock
`ifndef SFPL_CFG_SVH
`define SFPL_CFG_SVH
`define SFPL_CLK_NS 20
`define SFPL_UNLOCK_NS 100000
`define SFPL_UNLOCK_TOL_NS 20000
`define SFPL_OP_READ 8'h03
`define SFPL_OP_FAST 8'h0b
`define SFPL_OP_DOR 8'h3b
`define SFPL_OP_QOR 8'h6b
`define SFPL_OP_DIOR 8'hbb
`define SFPL_OP_QIOR 8'heb
`define SFPL_OP_READ4 8'h13
`define SFPL_OP_FAST4 8'h0c
`define SFPL_OP_DOR4 8'h3c
`define SFPL_OP_QOR4 8'h6c
`define SFPL_OP_DIOR4 8'hbc
`define SFPL_OP_QIOR4 8'hec
`define SFPL_OP_RDSR1 8'h05
`define SFPL_OP_CLSR 8'h30
`define SFPL_OP_ECCRD 8'h18
`define SFPL_OP_LCLR 8'ha6
`define SFPL_OP_PWRD 8'he7
`define SFPL_OP_PWPG 8'he8
`define SFPL_OP_UNLK 8'he9
`define SFPL_OP_PPBP 8'he3
`define SFPL_OP_PPBE 8'he4
`define SFPL_OP_ASPP 8'h2f
`define SFPL_DUMMY_FAST 4'h8
`define SFPL_DUMMY_QIO 4'h4
`define SFPL_CONT_NIBBLE 4'ha
`define SFPL_SR1_WIP 0
`define SFPL_SR1_PERR 6
`define SFPL_BOOT_ADDR 32'h0000_0000
`define SFPL_PROTECTION_CONFIG_REG_PASSWORD 2'h1
`define SFPL_PROTECTION_CONFIG_REG_BLANK 2'h3
`define SFPL_PROTECTION_CONFIG_REG_ILLEGAL 2'h0
`define SFPL_PW_BYTES 4'h8
`define SFPL_PW_RESET 64'hffff_ffff_ffff_ffff
`endif

// ==== sfpl_pkg.sv ====
// Types of the serial flash command front end with protection lock
`default_nettype none
package sfpl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_INST = 3'h1,
    ST_ADDR = 3'h2,
    ST_MODE = 3'h3,
    ST_DUMMY = 3'h4,
    ST_DIN = 3'h5,
    ST_DOUT = 3'h6,
    ST_SKIP = 3'h7
  } sfpl_state_e;

  typedef enum logic [3:0] {
    K_NONE = 4'h0,
    K_READ = 4'h1,
    K_STAT = 4'h2,
    K_CLSR = 4'h3,
    K_ECC = 4'h4,
    K_LCLR = 4'h5,
    K_PWRD = 4'h6,
    K_PWPG = 4'h7,
    K_UNLK = 4'h8,
    K_PPBP = 4'h9,
    K_PPBE = 4'ha,
    K_ASPP = 4'hb
  } sfpl_kind_e;

  typedef struct packed {
    sfpl_kind_e kind;
    logic [2:0] alanes;
    logic [2:0] dlanes;
    logic has_addr;
    logic addr4;
    logic has_mode;
    logic [3:0] dummy;
  } sfpl_cmd_s;
endpackage
`default_nettype wire

// ==== sfpl_top_unused_guard.sv ====
// Reserved file: holds no logic of the flash front end
`default_nettype none
`default_nettype wire

// ==== sfpl_top_asserts.sv ====
// Concurrent checks of the flash front end and protection lock
`default_nettype none
`include "sfpl_cfg.svh"
module sfpl_top_asserts (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic cs_n_in,
  input wire logic sw_reset_in,
  input wire logic busy_in,
  input wire logic read_prot_in,
  input wire logic [1:0] protection_config_reg_nv_in,
  input wire logic [31:0] arr_addr_out,
  input wire logic arr_rd_out,
  input wire logic arr_ecc_out,
  input wire logic ppb_prog_out,
  input wire logic ppb_erase_out,
  input wire logic asp_prog_out,
  input wire logic [1:0] asp_wdata_out,
  input wire logic [3:0] io_oe_out,
  input wire logic lock_out,
  input wire logic wip_out,
  input wire logic perr_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] rcnt_r;
  logic [3:0] rcnt_nxt;
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!nrst_in);
  // ------
  // Cycles since reset, saturating: outside password mode lock may only rise just after it
  // ------
  always_comb
  begin
    rcnt_nxt = (rcnt_r == 4'hf) ? rcnt_r : rcnt_r + 4'h1;
  end
  always_ff @(posedge clock_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rcnt_r <= 4'h0;
    else
      rcnt_r <= rcnt_nxt;
  end
  lock_set_a:
    assert property ($rose(nrst_in) && protection_config_reg_nv_in != 2'h1
      |-> ##[1:6] lock_out) else $error("lock not set by reset");
  sw_keep_a:
    assert property (sw_reset_in |=> $stable(lock_out))
      else $error("soft reset moved lock");
  no_set_a:
    assert property ($rose(lock_out) |-> protection_config_reg_nv_in == 2'h1
      || rcnt_r < 4'h8) else $error("lock set by command");
  pw_clear_a:
    assert property ($rose(nrst_in) && protection_config_reg_nv_in == 2'h1
      |-> !lock_out [*8]) else $error("lock set in password mode");
  fail_flags_a:
    assert property ($rose(perr_out) && !$past(lock_out)
      |-> !lock_out && wip_out)
      else $error("failure flags wrong");
  ppb_gate_a:
    assert property (ppb_prog_out || ppb_erase_out
      |-> lock_out ##1 !(ppb_prog_out || ppb_erase_out))
      else $error("protection bits changed while locked");
  mode_lock_a:
    assert property (asp_prog_out
      |-> protection_config_reg_nv_in == 2'h3 && asp_wdata_out != 2'h0)
      else $error("mode bits reprogrammed");
  busy_read_a:
    assert property (busy_in && $past(busy_in) |-> !arr_rd_out)
      else $error("array read during busy");
  ecc_boot_a:
    assert property (arr_rd_out && arr_ecc_out && read_prot_in
      |-> arr_addr_out == `SFPL_BOOT_ADDR)
      else $error("ecc read not redirected");
  lanes_a:
    assert property (io_oe_out != 4'h0
      |-> io_oe_out inside {4'h2, 4'h3, 4'hf})
      else $error("illegal lane enables");
  idle_a:
    assert property (cs_n_in [*8] |-> io_oe_out == 4'h0)
      else $error("drive outside frame");
  cover property ($rose(lock_out) && rcnt_r == 4'hf);
  cover property (ppb_prog_out);
  cover property (io_oe_out == 4'hf);
  cover property ($rose(perr_out));
endmodule
bind sfpl_top sfpl_top_asserts sfpl_top_asserts_inst (
  .clock_in(clock_in), .nrst_in(nrst_in), .cs_n_in(cs_n_in),
  .sw_reset_in(sw_reset_in), .busy_in(busy_in),
  .read_prot_in(read_prot_in), .protection_config_reg_nv_in(protection_config_reg_nv_in),
  .arr_addr_out(arr_addr_out), .arr_rd_out(arr_rd_out),
  .arr_ecc_out(arr_ecc_out), .ppb_prog_out(ppb_prog_out),
  .ppb_erase_out(ppb_erase_out), .asp_prog_out(asp_prog_out),
  .asp_wdata_out(asp_wdata_out), .io_oe_out(io_oe_out),
  .lock_out(lock_out), .wip_out(wip_out), .perr_out(perr_out)
);
`default_nettype wire

// ==== sfpl_host_model.sv ====
// Host serial controller model: select, serial clock and IO lines
`default_nettype none
module sfpl_host_model (
  output logic cs_n_out,
  output logic sck_out,
  output logic [3:0] io_out,
  input wire logic [3:0] io_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    io_out = 4'h0;
  end
  // ------
  // One 160 ns clock; released lanes toggle so no stale level survives
  // ------
  task automatic grp(input logic [3:0] v, input logic [3:0] m,
    input logic drv, output logic [3:0] s);
    io_out = drv ? (v | (~io_out & ~m)) : ~io_out;
    #80 sck_out = 1'b1;
    #70 s = io_in;
    #10 sck_out = 1'b0;
  endtask
  task automatic shift(input logic [63:0] v, input int n, input int l,
    input logic drv, output logic [63:0] r);
    logic [3:0] m;
    logic [3:0] s;
    m = 4'((5'h1 << l) - 5'h1);
    r = 64'h0;
    for (int i = n / l - 1; i >= 0; i--)
    begin
      grp(4'(v >> (i * l)) & m, m, drv, s);
      r = (r << l) | 64'((l == 1) ? {3'h0, s[1]} : s & m);
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic [63:0] a,
    input int an, input int al, input int dm, input int dn, input int dl,
    output logic [63:0] r);
    logic [63:0] x;
    cs_n_out = 1'b0;
    #80;
    if (op != 8'h00)
      shift(64'(op), 8, 1, 1'b1, x);
    if (an > 0)
      shift(a, an, al, 1'b1, x);
    if (dm > 0)
      shift(64'h0, dm, 1, 1'b0, x);
    r = 64'h0;
    if (dn > 0)
      shift(64'h0, dn, dl, 1'b0, r);
    #80 cs_n_out = 1'b1;
    #400;
  endtask
endmodule
`default_nettype wire

// ==== sfpl_top_bench.sv ====
// Self-checking bench of the flash front end and protection lock
`default_nettype none
`include "sfpl_cfg.svh"
module sfpl_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int UCYC = 2000;
  localparam logic [7:0] OP[8] = '{`SFPL_OP_READ, `SFPL_OP_DOR,
    `SFPL_OP_QOR, `SFPL_OP_DIOR, `SFPL_OP_QIOR, `SFPL_OP_READ4,
    `SFPL_OP_QIOR, 8'h00};
  localparam int AN[8] = '{24, 24, 24, 32, 32, 32, 32, 32};
  localparam int AL[8] = '{1, 1, 1, 2, 4, 1, 4, 4};
  localparam int DM[8] = '{0, 8, 8, 0, 4, 0, 4, 4};
  localparam int DL[8] = '{1, 2, 4, 2, 4, 1, 4, 4};
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic sw_reset = 1'b0;
  logic busy = 1'b0;
  logic rprot = 1'b0;
  logic [1:0] protection_config_reg = 2'h3;
  logic [7:0] rdata = 8'h00;
  logic cs_n;
  logic sck;
  logic [3:0] io_h;
  logic [3:0] io_d;
  logic [3:0] io_oe;
  logic [3:0] io_w;
  logic [31:0] arr_addr;
  logic lock;
  logic write_in_progress_flag;
  logic perr;
  logic [63:0] rd;
  logic [63:0] obs_v;
  logic obs_tgl = 1'b0;
  logic [63:0] exp_q[$];
  int err_total = 0;
  int check_count = 0;
  always #10 clock_in = ~clock_in;
  assign io_w = (io_oe & io_d) | (~io_oe & io_h);
  always @(negedge clock_in) rdata <= arr_addr[7:0] ^ 8'h3c;
  sfpl_host_model sfpl_host_model_inst (.cs_n_out(cs_n), .sck_out(sck),
    .io_out(io_h), .io_in(io_w));
  sfpl_top #(.UNLOCK_CYC(UCYC)) sfpl_top_inst (.clock_in(clock_in),
    .nrst_in(nrst_in), .cs_n_in(cs_n), .sck_in(sck), .io_in(io_w),
    .io_out(io_d), .io_oe_out(io_oe), .sw_reset_in(sw_reset),
    .busy_in(busy), .read_prot_in(rprot), .protection_config_reg_nv_in(protection_config_reg),
    .arr_rdata_in(rdata), .arr_addr_out(arr_addr), .arr_rd_out(),
    .arr_ecc_out(), .ppb_prog_out(), .ppb_erase_out(), .asp_prog_out(),
    .asp_wdata_out(), .lock_out(lock), .wip_out(write_in_progress_flag), .perr_out(perr));
  // ------
  // Drivers note the expectation; the monitor compares oldest first
  // ------
  task automatic finish_test();
    if (err_total == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic note(input logic [63:0] e, input logic [63:0] g);
    exp_q.push_back(e);
    obs_v = g;
    obs_tgl = ~obs_tgl;
    #1;
  endtask
  always @(obs_tgl)
  begin
    logic [63:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : 'x;
    check_count++;
    if (e !== obs_v)
    begin
      err_total++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, obs_v);
    end
  end
  task automatic fr(input logic [7:0] op, input logic [63:0] a,
    input int an, input int al, input int dm, input int dn, input int dl);
    @(negedge clock_in);
    sfpl_host_model_inst.frame(op, a, an, al, dm, dn, dl, rd);
  endtask
  task automatic flg(input logic [2:0] e);
    @(negedge clock_in);
    note(64'(e), 64'({lock, write_in_progress_flag, perr}));
  endtask
  task automatic st(input logic [7:0] e);
    fr(`SFPL_OP_RDSR1, 0, 0, 1, 0, 8, 1);
    note(64'(e), rd);
  endtask
  task automatic do_reset(input logic [1:0] m);
    @(negedge clock_in);
    nrst_in = 1'b0;
    protection_config_reg = m;
    repeat (4) @(negedge clock_in);
    nrst_in = 1'b1;
    repeat (8) @(negedge clock_in);
  endtask
  initial
  begin
    #1000000;
    err_total++;
    finish_test();
  end
  initial
  begin
    logic [31:0] ad;
    logic [63:0] a;
    ad = $urandom(83328);
    do_reset(2'h3);
    flg(3'h4);
    @(negedge clock_in) sw_reset = 1'b1;
    @(negedge clock_in) sw_reset = 1'b0;
    flg(3'h4);
    for (int k = 0; k < 8; k++)
    begin
      ad = $urandom() & 32'h00ff_fff0;
      a = (AL[k] > 1) ? {ad[23:0], (k == 6) ? 8'ha5 : 8'h00}
        : (k == 5) ? ad : ad[23:0];
      fr(OP[k], a, AN[k], AL[k], DM[k], 16, DL[k]);
      note({ad[7:0] ^ 8'h3c, (ad[7:0] + 8'h01) ^ 8'h3c}, rd);
    end
    @(negedge clock_in) busy = 1'b1;
    st(8'h01);
    @(negedge clock_in) busy = 1'b0;
    @(negedge clock_in) rprot = 1'b1;
    fr(`SFPL_OP_ECCRD, ad, 32, 1, 8, 8, 1);
    note(64'h3c, rd);
    @(negedge clock_in) rprot = 1'b0;
    a = {$urandom(), $urandom()};
    ad = $urandom();
    fr(`SFPL_OP_PWPG, a, 64, 1, 0, 0, 1);
    fr(`SFPL_OP_PWPG, {ad, 32'hffff_ffff}, 64, 1, 0, 0, 1);
    fr(`SFPL_OP_PWRD, 64'h0, 0, 1, 0, 64, 1);
    note(a & {ad, 32'hffff_ffff}, rd);
    flg(3'h4);
    fr(`SFPL_OP_ASPP, 64'hfb, 8, 1, 0, 0, 1);
    fr(`SFPL_OP_PPBP, ad, 32, 1, 0, 0, 1);
    flg(3'h4);
    fr(`SFPL_OP_LCLR, 64'h0, 1, 1, 0, 0, 1);
    flg(3'h4);
    fr(`SFPL_OP_LCLR, 0, 0, 1, 0, 0, 1);
    flg(3'h0);
    fr(`SFPL_OP_PPBE, 0, 0, 1, 0, 0, 1);
    flg(3'h3);
    st(8'h41);
    fr(`SFPL_OP_CLSR, 0, 0, 1, 0, 0, 1);
    flg(3'h0);
    do_reset(2'h1);
    flg(3'h0);
    fr(`SFPL_OP_ASPP, 64'hf9, 8, 1, 0, 0, 1);
    a = {$urandom(), $urandom() & 32'hffff_fffe};
    fr(`SFPL_OP_UNLK, a, 64, 1, 0, 0, 1);
    flg(3'h3);
    fr(`SFPL_OP_CLSR, 0, 0, 1, 0, 0, 1);
    fr(`SFPL_OP_UNLK, '1, 64, 1, 0, 0, 1);
    flg(3'h0);
    fr(`SFPL_OP_PWPG, 64'h0, 64, 1, 0, 0, 1);
    repeat (UCYC) @(negedge clock_in);
    fr(`SFPL_OP_UNLK, '1, 64, 1, 0, 0, 1);
    flg(3'h4);
    finish_test();
  end
endmodule
`default_nettype wire
